// *** core/nibp_regs.svh ***
// Register offsets, field positions, reset values and timing for the NIBP glue block
`ifndef NIBP_REGS_SVH
`define NIBP_REGS_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define NIBP_OFF_PORT1 8'h00
`define NIBP_OFF_PUMP 8'h04
`define NIBP_OFF_PULSE 8'h08
`define NIBP_OFF_VENT 8'h0C
`define NIBP_OFF_TRIP 8'h10
`define NIBP_OFF_STATUS 8'h14
// ****************************************
// Field positions
// ****************************************
`define NIBP_P1_VENT 3
`define NIBP_P1_ORIF_LSB 4
`define NIBP_PUMP_RUN 0
`define NIBP_PUMP_NEO 1
`define NIBP_PUMP_DUTY_LSB 8
`define NIBP_PULSE_GAIN_LSB 0
`define NIBP_PULSE_OVR 2
`define NIBP_PULSE_CLR 3
`define NIBP_VENT_CPU_EN 0
`define NIBP_VENT_END_DUMP 1
`define NIBP_VENT_BLEED_LSB 8
`define NIBP_TRIP_ADULT_LSB 0
`define NIBP_TRIP_NEO_LSB 16
// ****************************************
// Reset values and codes
// ****************************************
`define NIBP_RST_PORT1 8'h00
`define NIBP_RST_PUMP 32'h0000_8000
`define NIBP_RST_PULSE 32'h0000_0000
`define NIBP_RST_VENT 32'h0000_0000
`define NIBP_RST_TRIP 32'h01E0_03C0
`define NIBP_GAIN_28 2'h0
`define NIBP_GAIN_56 2'h1
`define NIBP_GAIN_111 2'h2
`define NIBP_GAIN_222 2'h3
`define NIBP_BLEED_FULL 8'hFF
// ****************************************
// Memory map boundaries (byte addresses)
// ****************************************
`define NIBP_A_8K 16'h2000
`define NIBP_A_32K 16'h8000
`define NIBP_A_40K 16'hA000
`define NIBP_A_56K 16'hE000
// ****************************************
// Timing
// ****************************************
`define NIBP_MCLK_HZ 10000000
`define NIBP_SAMPLE_HZ 250
`endif

// *** core/nibp_pkg.sv ***
// Types shared by the NIBP glue block
package nibp_pkg;
  typedef enum logic [1:0] {NIBP_MAP_NONE, NIBP_MAP_PROG, NIBP_MAP_NVRAM, NIBP_MAP_IO} nibp_map_t;
  typedef enum logic [1:0] {NIBP_PUMP_OFF, NIBP_PUMP_FULL, NIBP_PUMP_PWM} nibp_pump_t;
endpackage

// *** core/nibp_glue.sv ***
// NIBP decode, actuator drive and overpressure interlock
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "nibp_regs.svh"

module nibp_glue #(
  parameter int SAMPLE_DIV = `NIBP_MCLK_HZ / `NIBP_SAMPLE_HZ,
  parameter int PWM_DIV = 4
) (
  input wire logic mclk_i, // 10 MHz clock
  input wire logic rst_i, // Async reset, active high
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB direction
  input wire logic [7:0] paddr_i, // APB byte address
  input wire logic [31:0] pwdata_i, // APB write data
  output logic [31:0] prdata_o, // APB read data
  output logic pready_o, // APB ready
  output logic pslverr_o, // APB error, unmapped address
  input wire logic [15:0] cpu_addr_i, // Processor address
  input wire logic module_mode_select_i, // High selects module-mode map
  input wire logic memory_bank_select_i, // Bank bit
  output logic prog_sel_o, // Program memory select
  output logic nvram_sel_o, // Nonvolatile RAM select
  output logic io_sel_o, // Converter I/O select
  input wire logic overpressure_switch_i, // Switch closed, async pin
  input wire logic module_reset_n_i, // Module reset pin, active low
  input wire logic pneu_vent_enable_i, // Pneumatics controller enable pin
  input wire logic [9:0] ovp_code_i, // Overpressure transducer code
  output logic cpu_reset_n_o, // Buffered processor reset
  output logic overpressure_flag_o, // Latched overpressure
  output logic nmi_o, // NMI pulse
  output logic hsi_bit1_o, // Flag copy for confirmation
  output logic vent_valve_ctl_o, // Dump valve, high energises
  output logic orifice_valve_a_o, // Bleed orifice valve
  output logic orifice_valve_b_o, // Bleed orifice valve
  output logic orifice_valve_c_o, // Bleed orifice valve
  output logic orifice_valve_d_o, // Bleed orifice valve, optional
  output logic vent_valve_enable_o, // Gated dump enable
  output logic [7:0] prop_bleed_valve_o, // Proportional bleed drive
  output logic pump_o, // Pump drive, active high
  output logic [1:0] gain_sel_o, // Pulse channel gain code
  output logic pulse_clear_o, // Pulse channel clear
  output logic neonate_flag_n_o, // Low while a neonate is inferred from an open orifice valve
  output logic overpressure_compare_n_o, // Low on transducer trip
  output logic adc_sample_o // Sampling strobe
);

  // ****************************************
  // Decode function
  // ****************************************

  // Alternate map has no I/O window
  function automatic nibp_pkg::nibp_map_t map_decode(
    input logic [15:0] a,
    input logic mode,
    input logic bank
  );
    nibp_pkg::nibp_map_t m;
    m = nibp_pkg::NIBP_MAP_NONE;
    if (!mode) begin
      m = (a < `NIBP_A_32K) ? nibp_pkg::NIBP_MAP_PROG : nibp_pkg::NIBP_MAP_NVRAM;
    end else if (a >= `NIBP_A_56K) begin
      m = nibp_pkg::NIBP_MAP_IO;
    end else if (a >= `NIBP_A_40K) begin
      m = nibp_pkg::NIBP_MAP_NONE;
    end else if (a >= `NIBP_A_32K) begin
      m = nibp_pkg::NIBP_MAP_NVRAM;
    end else if (bank || a < `NIBP_A_8K) begin
      m = nibp_pkg::NIBP_MAP_PROG;
    end else begin
      m = nibp_pkg::NIBP_MAP_NVRAM;
    end
    return m;
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] port1_q;
  logic [31:0] pump_reg_q;
  logic [31:0] pulse_reg_q;
  logic [31:0] vent_reg_q;
  logic [31:0] trip_reg_q;
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  logic [2:0] pin_s3_q;
  logic [2:0] pin_f_q;
  logic flag_q;
  logic flag_d;
  logic nmi_q;
  logic neo_n_q;
  logic cmp_n_q;
  logic pump_q;
  logic [15:0] samp_cnt_q;
  logic samp_q;
  logic [7:0] pwm_div_q;
  logic pwm_en;
  logic [7:0] pwm_cnt_q;
  logic ready_q;
  logic err_q;
  logic [31:0] rdata_q;
  logic vent_en_q;
  logic vent_ctl_q;
  logic [3:0] orif_q;
  logic [7:0] bleed_q;
  logic [1:0] gain_q;
  logic clr_q;
  logic rst_n_q;
  logic [2:0] sel_q;
  nibp_pkg::nibp_pump_t pump_mode;
  nibp_pkg::nibp_map_t map_now;
  logic apb_setup;
  logic apb_wr;
  logic neo_mode;
  logic vent_en_d;
  logic [9:0] trip_ref;

  // ****************************************
  // APB slave
  // ****************************************

  // Read data and error captured in setup so they come from flip-flops
  assign apb_setup = psel_i & ~penable_i;
  assign apb_wr = psel_i & penable_i & ready_q & pwrite_i & ~err_q;

  // One wait-free access phase: ready follows setup by one edge
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ready_q <= 1'b0;
      err_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ready_q <= apb_setup;
      if (apb_setup) begin
        err_q <= 1'b0;
        case (paddr_i)
          `NIBP_OFF_PORT1: rdata_q <= {24'h00_0000, port1_q};
          `NIBP_OFF_PUMP: rdata_q <= pump_reg_q;
          `NIBP_OFF_PULSE: rdata_q <= pulse_reg_q;
          `NIBP_OFF_VENT: rdata_q <= vent_reg_q;
          `NIBP_OFF_TRIP: rdata_q <= trip_reg_q;
          `NIBP_OFF_STATUS: rdata_q <= {25'h000_0000, rst_n_q, pin_f_q[0],
            memory_bank_select_i, module_mode_select_i, cmp_n_q, neo_n_q, flag_q};
          default: begin
            rdata_q <= 32'h0000_0000;
            err_q <= 1'b1;
          end
        endcase
      end else if (!psel_i) begin
        err_q <= 1'b0;
      end
    end
  end

  // Software registers; status is read-only, writes there are ignored
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      port1_q <= `NIBP_RST_PORT1;
      pump_reg_q <= `NIBP_RST_PUMP;
      pulse_reg_q <= `NIBP_RST_PULSE;
      vent_reg_q <= `NIBP_RST_VENT;
      trip_reg_q <= `NIBP_RST_TRIP;
    end else if (apb_wr) begin
      case (paddr_i)
        `NIBP_OFF_PORT1: port1_q <= pwdata_i[7:0];
        `NIBP_OFF_PUMP: pump_reg_q <= pwdata_i;
        `NIBP_OFF_PULSE: pulse_reg_q <= pwdata_i;
        `NIBP_OFF_VENT: vent_reg_q <= pwdata_i;
        `NIBP_OFF_TRIP: trip_reg_q <= pwdata_i;
        default: port1_q <= port1_q;
      endcase
    end
  end

  assign prdata_o = rdata_q;
  assign pready_o = ready_q;
  assign pslverr_o = err_q & ready_q;

  // ****************************************
  // Address decoder
  // ****************************************

  // Registered selects cost one cycle of decode latency
  assign map_now = map_decode(cpu_addr_i, module_mode_select_i, memory_bank_select_i);

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sel_q <= 3'h0;
    end else begin
      sel_q[0] <= (map_now == nibp_pkg::NIBP_MAP_PROG);
      sel_q[1] <= (map_now == nibp_pkg::NIBP_MAP_NVRAM);
      sel_q[2] <= (map_now == nibp_pkg::NIBP_MAP_IO);
    end
  end

  assign prog_sel_o = sel_q[0];
  assign nvram_sel_o = sel_q[1];
  assign io_sel_o = sel_q[2];

  // ****************************************
  // Pin synchronisers
  // ****************************************

  // Bit 0 module reset, bit 1 switch, bit 2 pneumatics enable
  // A change is taken only once stages two and three agree
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
      pin_s3_q <= 3'h0;
      pin_f_q <= 3'h0;
    end else begin
      pin_s1_q <= {pneu_vent_enable_i, overpressure_switch_i, module_reset_n_i};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      for (int i = 0; i < 3; i++) begin
        if (pin_s2_q[i] == pin_s3_q[i]) begin
          pin_f_q[i] <= pin_s3_q[i];
        end
      end
    end
  end

  // Processor reset held low through our own reset
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rst_n_q <= 1'b0;
    end else begin
      rst_n_q <= pin_f_q[0];
    end
  end

  assign cpu_reset_n_o = rst_n_q;

  // ****************************************
  // Overpressure interlock
  // ****************************************

  // Trip from the clean switch level or the transducer comparator
  assign flag_d = flag_q | pin_f_q[1] | ~cmp_n_q;

  // Sticky: only the block reset clears it, software has no path
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      flag_q <= 1'b0;
      nmi_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
      nmi_q <= flag_d & ~flag_q;
    end
  end

  assign overpressure_flag_o = flag_q;
  assign hsi_bit1_o = flag_q;
  assign nmi_o = nmi_q;

  // Lower trip point while the neonate flag is low
  assign trip_ref = neo_n_q ? trip_reg_q[`NIBP_TRIP_ADULT_LSB +: 10]
                            : trip_reg_q[`NIBP_TRIP_NEO_LSB +: 10];

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cmp_n_q <= 1'b1;
    end else begin
      cmp_n_q <= ~(ovp_code_i > trip_ref);
    end
  end

  assign overpressure_compare_n_o = cmp_n_q;

  // Neonate inference: pump running with any orifice valve open (bit low)
  // Held until pump-up request ends so the trip point does not chatter
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      neo_n_q <= 1'b1;
    end else if (!pump_reg_q[`NIBP_PUMP_RUN]) begin
      neo_n_q <= 1'b1;
    end else if (pump_q && port1_q[7:`NIBP_P1_ORIF_LSB] != 4'hF) begin
      neo_n_q <= 1'b0;
    end
  end

  assign neonate_flag_n_o = neo_n_q;

  // ****************************************
  // Rate dividers
  // ****************************************

  // Sampling strobe, one cycle wide
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      samp_cnt_q <= 16'h0000;
      samp_q <= 1'b0;
    end else if (samp_cnt_q == 16'(SAMPLE_DIV - 1)) begin
      samp_cnt_q <= 16'h0000;
      samp_q <= 1'b1;
    end else begin
      samp_cnt_q <= samp_cnt_q + 16'h0001;
      samp_q <= 1'b0;
    end
  end

  assign adc_sample_o = samp_q;

  // PWM step enable and 8-bit ramp
  assign pwm_en = (pwm_div_q == 8'(PWM_DIV - 1));

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pwm_div_q <= 8'h00;
      pwm_cnt_q <= 8'h00;
    end else begin
      pwm_div_q <= pwm_en ? 8'h00 : pwm_div_q + 8'h01;
      if (pwm_en) begin
        pwm_cnt_q <= pwm_cnt_q + 8'h01;
      end
    end
  end

  // ****************************************
  // Pump drive
  // ****************************************
  assign neo_mode = pump_reg_q[`NIBP_PUMP_NEO] | ~neo_n_q;

  // Interlock outranks any software request
  always_comb begin
    pump_mode = nibp_pkg::NIBP_PUMP_OFF;
    if (flag_q) begin
      pump_mode = nibp_pkg::NIBP_PUMP_OFF;
    end else if (pump_reg_q[`NIBP_PUMP_RUN]) begin
      pump_mode = pump_reg_q[`NIBP_PUMP_NEO] ? nibp_pkg::NIBP_PUMP_PWM
                                              : nibp_pkg::NIBP_PUMP_FULL;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pump_q <= 1'b0;
    end else begin
      case (pump_mode)
        nibp_pkg::NIBP_PUMP_FULL: pump_q <= 1'b1;
        nibp_pkg::NIBP_PUMP_PWM:
          pump_q <= pwm_cnt_q < pump_reg_q[`NIBP_PUMP_DUTY_LSB +: 8];
        default: pump_q <= 1'b0;
      endcase
    end
  end

  assign pump_o = pump_q;

  // ****************************************
  // Valves
  // ****************************************

  // Both enables must agree; trip or end of measurement vents the cuff
  assign vent_en_d = vent_reg_q[`NIBP_VENT_CPU_EN] & pin_f_q[2] & ~flag_q
                   & ~vent_reg_q[`NIBP_VENT_END_DUMP];

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      vent_en_q <= 1'b0;
      vent_ctl_q <= 1'b0;
      orif_q <= 4'h0;
      bleed_q <= 8'h00;
    end else begin
      vent_en_q <= vent_en_d;
      vent_ctl_q <= port1_q[`NIBP_P1_VENT] & vent_en_d;
      orif_q <= port1_q[7:`NIBP_P1_ORIF_LSB];
      // Bleed stays at its set opening during the final dump
      bleed_q <= flag_q ? `NIBP_BLEED_FULL
                        : vent_reg_q[`NIBP_VENT_BLEED_LSB +: 8];
    end
  end

  assign vent_valve_enable_o = vent_en_q;
  assign vent_valve_ctl_o = vent_ctl_q;
  assign orifice_valve_a_o = orif_q[0];
  assign orifice_valve_b_o = orif_q[1];
  assign orifice_valve_c_o = orif_q[2];
  assign orifice_valve_d_o = orif_q[3];
  assign prop_bleed_valve_o = bleed_q;

  // ****************************************
  // Pulse channel controls
  // ****************************************

  // Without override the gain follows the patient mode
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      gain_q <= `NIBP_GAIN_28;
      clr_q <= 1'b0;
    end else begin
      if (pulse_reg_q[`NIBP_PULSE_OVR]) begin
        gain_q <= pulse_reg_q[`NIBP_PULSE_GAIN_LSB +: 2];
      end else begin
        gain_q <= neo_mode ? `NIBP_GAIN_111 : `NIBP_GAIN_28;
      end
      clr_q <= pulse_reg_q[`NIBP_PULSE_CLR];
    end
  end

  assign gain_sel_o = gain_q;
  assign pulse_clear_o = clr_q;

endmodule

// *** dv/nibp_glue_checker.sv ***
// Concurrent checks on the NIBP glue block ports
`timescale 1ns/1ps
module nibp_glue_checker #(
  parameter int SAMPLE_DIV = 20
) (
  input wire logic mclk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic [15:0] cpu_addr_i, // Processor address
  input wire logic module_mode_select_i, // Map select
  input wire logic memory_bank_select_i, // Bank bit
  input wire logic prog_sel_o, // Program select
  input wire logic nvram_sel_o, // RAM select
  input wire logic io_sel_o, // Converter select
  input wire logic overpressure_switch_i, // Switch pin
  input wire logic module_reset_n_i, // Module reset pin
  input wire logic [9:0] ovp_code_i, // Transducer code
  input wire logic cpu_reset_n_o, // Processor reset
  input wire logic overpressure_flag_o, // Latched flag
  input wire logic nmi_o, // NMI pulse
  input wire logic vent_valve_ctl_o, // Dump drive
  input wire logic vent_valve_enable_o, // Dump enable
  input wire logic [7:0] prop_bleed_valve_o, // Bleed drive
  input wire logic pump_o, // Pump drive
  input wire logic adc_sample_o // Sampling strobe
);
  // ****************************************
  // Helper logic and assertions
  // ****************************************
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  logic [15:0] gap_q;
  logic seen_q;
  // Cycles since the last strobe; the first strobe has no reference gap
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      gap_q <= 16'h0000;
      seen_q <= 1'b0;
    end else if (adc_sample_o) begin
      gap_q <= 16'h0000;
      seen_q <= 1'b1;
    end else begin
      gap_q <= gap_q + 16'h0001;
    end
  end
  chk_prog_map: assert property (!$past(rst_i) |-> prog_sel_o == ($past(cpu_addr_i) <
    ((!$past(module_mode_select_i) || $past(memory_bank_select_i)) ? 16'h8000 : 16'h2000)))
    else $error("program select wrong");
  chk_io_map: assert property (!$past(rst_i) |-> io_sel_o ==
    ($past(module_mode_select_i) && $past(cpu_addr_i) >= 16'hE000))
    else $error("converter select wrong");
  chk_pump_gate: assert property (overpressure_flag_o && $past(overpressure_flag_o) |-> !pump_o)
    else $error("pump on under overpressure");
  chk_nmi_edge: assert property (nmi_o == $rose(overpressure_flag_o))
    else $error("nmi not tied to flag edge");
  chk_flag_sticky: assert property (overpressure_flag_o |=> overpressure_flag_o)
    else $error("flag cleared without reset");
  chk_vent_forced: assert property (overpressure_flag_o && $past(overpressure_flag_o) |->
    !vent_valve_enable_o && !vent_valve_ctl_o && prop_bleed_valve_o == 8'hFF)
    else $error("not vented under overpressure");
  chk_dump_gated: assert property (vent_valve_ctl_o |-> vent_valve_enable_o)
    else $error("dump energised without enable");
  chk_switch_trip: assert property ($rose(overpressure_switch_i) |-> ##[1:8] overpressure_flag_o)
    else $error("switch did not latch");
  chk_switch_sync: assert property ($rose(overpressure_switch_i) && !overpressure_flag_o &&
    ovp_code_i < 10'h100 && $past(ovp_code_i) < 10'h100 |-> !overpressure_flag_o ##1 !overpressure_flag_o)
    else $error("switch not synchronised");
  chk_cpu_rst_hold: assert property (!module_reset_n_i [*8] |-> !cpu_reset_n_o)
    else $error("processor reset not passed");
  chk_cpu_rst_rise: assert property ($rose(cpu_reset_n_o) |-> $past(module_reset_n_i, 3))
    else $error("processor reset released early");
  chk_sample_gap: assert property (adc_sample_o && seen_q |-> gap_q == SAMPLE_DIV - 1)
    else $error("sampling period wrong");
endmodule

// *** dv/nibp_pneu_model.sv ***
// Pneumatics board model: cuff pressure, overpressure switch, dump enable
`timescale 1ns/1ps
module nibp_pneu_model #(
  parameter logic [9:0] SW_LEVEL = 10'h3F8
) (
  input wire logic mclk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic pump_i, // Pump drive
  input wire logic dump_i, // Dump valve energised
  input wire logic en_req_i, // Bench allows dump energise
  input wire logic sw_req_i, // Bench forces switch closed
  output logic pneu_vent_enable_o, // Enable pin
  output logic overpressure_switch_o, // Switch pin
  output logic [9:0] ovp_code_o // Transducer code
);
  // ****************************************
  // Cuff and pins
  // ****************************************
  // Cuff fills only with pump on and dump shut; a de-energised dump vents it
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ovp_code_o <= 10'h000;
    end else if (pump_i && dump_i && ovp_code_o != 10'h3FF) begin
      ovp_code_o <= ovp_code_o + 10'h001;
    end else if (!dump_i) begin
      ovp_code_o <= (ovp_code_o > 10'h004) ? ovp_code_o - 10'h004 : 10'h000;
    end
  end
  // Pins move just after an edge, like the real controller's outputs
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pneu_vent_enable_o <= 1'b0;
      overpressure_switch_o <= 1'b0;
    end else begin
      pneu_vent_enable_o <= en_req_i;
      overpressure_switch_o <= sw_req_i || ovp_code_o >= SW_LEVEL;
    end
  end
endmodule

// *** dv/nibp_tb.sv ***
// Self-checking bench for the NIBP glue block
`timescale 1ns/1ps
`include "nibp_regs.svh"
module testbench;
  // ****************************************
  // Signals, tasks and expectations
  // ****************************************
  localparam int SDIV = 20;
  localparam int PWM = 4;
  logic mclk_i = 1'b0, rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o;
  logic [15:0] cpu_addr_i = 16'h0000;
  logic module_mode_select_i = 1'b1, memory_bank_select_i = 1'b1, module_reset_n_i = 1'b1;
  logic en_req = 1'b0, sw_req = 1'b0, pready_o, pslverr_o, prog_sel_o, nvram_sel_o, io_sel_o;
  logic overpressure_switch_i, pneu_vent_enable_i, cpu_reset_n_o, overpressure_flag_o, nmi_o;
  logic hsi_bit1_o, vent_valve_ctl_o, orifice_valve_a_o, orifice_valve_b_o, orifice_valve_c_o;
  logic orifice_valve_d_o, vent_valve_enable_o, pump_o, pulse_clear_o, neonate_flag_n_o;
  logic overpressure_compare_n_o, adc_sample_o;
  logic [9:0] ovp_code_i;
  logic [7:0] prop_bleed_valve_o;
  logic [1:0] gain_sel_o;
  logic [31:0] lfsr_q = 32'h0000_D1FE;
  logic [15:0] corner [10] = '{16'h0000, 16'h1FFF, 16'h2000, 16'h7FFF, 16'h8000,
    16'h9FFF, 16'hA000, 16'hDFFF, 16'hE000, 16'hFFFF};
  int failures = 0, cmp_count = 0, cyc = 0;
  // Every DUT port has a bench signal of its own name
  nibp_glue #(.SAMPLE_DIV(SDIV), .PWM_DIV(PWM)) u_dut (.*);
  nibp_pneu_model u_pneu (.mclk_i, .rst_i, .pump_i(pump_o), .dump_i(vent_valve_ctl_o),
    .en_req_i(en_req), .sw_req_i(sw_req), .pneu_vent_enable_o(pneu_vent_enable_i),
    .overpressure_switch_o(overpressure_switch_i), .ovp_code_o(ovp_code_i));
  // Free-running clock
  initial begin
    forever #50 mclk_i = ~mclk_i;
  end
  // Hang guard
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      tally_and_finish();
    end
  end
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected {program, RAM, converter} selects
  function automatic logic [2:0] exp_map(input logic [15:0] a, input logic m, input logic b);
    if (!m) return (a < 16'h8000) ? 3'h4 : 3'h2;
    if (a < (b ? 16'h8000 : 16'h2000)) return 3'h4;
    if (a < 16'hA000) return 3'h2;
    return (a >= 16'hE000) ? 3'h1 : 3'h0;
  endfunction
  task automatic tally_and_finish();
    if (failures == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t bit %b expected %b", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  // One APB transfer; the slave's ready decides when it ends, not a fixed count
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd, output logic err);
    int n;
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= wd;
    tick(1);
    penable_i <= 1'b1;
    n = 0;
    do begin
      tick(1);
      n++;
    end while (pready_o !== 1'b1 && n < 16);
    if (n >= 16) failures++;
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    tick(1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk_word(r, exp);
    chk_bit(e, exp_err);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [31:0] v;
    int i;
    int hi;
    tick(4);
    rst_i <= 1'b0;
    tick(1);
    rd_chk(`NIBP_OFF_PORT1, 32'h0, 1'b0);
    rd_chk(`NIBP_OFF_PUMP, `NIBP_RST_PUMP, 1'b0);
    rd_chk(`NIBP_OFF_PULSE, `NIBP_RST_PULSE, 1'b0);
    rd_chk(`NIBP_OFF_VENT, `NIBP_RST_VENT, 1'b0);
    rd_chk(`NIBP_OFF_TRIP, `NIBP_RST_TRIP, 1'b0);
    wr(8'h20, 32'hFFFF_FFFF);
    rd_chk(8'h20, 32'h0, 1'b1);
    chk_bit(pump_o, 1'b0);
    chk_bit(hsi_bit1_o, 1'b0);
    // Map edges in every mode and bank, then random addresses
    for (i = 0; i < 64; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      cpu_addr_i <= (i < 40) ? corner[i / 4] : lfsr_q[15:0];
      module_mode_select_i <= (i < 40) ? i[0] : lfsr_q[16];
      memory_bank_select_i <= (i < 40) ? i[1] : lfsr_q[17];
      tick(2);
      v = exp_map(cpu_addr_i, module_mode_select_i, memory_bank_select_i);
      chk_word({prog_sel_o, nvram_sel_o, io_sel_o}, v);
    end
    // Every gain code by override, clear following bit 0
    for (i = 0; i < 4; i++) begin
      wr(`NIBP_OFF_PULSE, {28'h0, i[0], 1'b1, i[1:0]});
      tick(2);
      chk_word(gain_sel_o, i[1:0]);
      chk_bit(pulse_clear_o, i[0]);
    end
    wr(`NIBP_OFF_PULSE, 32'h0);
    tick(2);
    chk_word(gain_sel_o, `NIBP_GAIN_28);
    wr(`NIBP_OFF_PUMP, 32'h0000_8002);
    tick(2);
    chk_word(gain_sel_o, `NIBP_GAIN_111);
    // Random valve patterns with both dump enables given
    en_req <= 1'b1;
    for (i = 0; i < 6; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      v = lfsr_q;
      wr(`NIBP_OFF_PORT1, {24'h0, v[7:0]});
      wr(`NIBP_OFF_VENT, {16'h0, v[15:8], 8'h01});
      tick(2);
      for (hi = 0; hi < 12 && vent_valve_ctl_o !== v[3]; hi++) tick(1);
      chk_word({orifice_valve_d_o, orifice_valve_c_o, orifice_valve_b_o, orifice_valve_a_o,
        vent_valve_ctl_o}, v[7:3]);
      chk_word(prop_bleed_valve_o, v[15:8]);
    end
    wr(`NIBP_OFF_PORT1, 32'h0000_00F8);
    en_req <= 1'b0;
    for (hi = 0; hi < 12 && vent_valve_enable_o !== 1'b0; hi++) tick(1);
    chk_bit(vent_valve_ctl_o, 1'b0);
    en_req <= 1'b1;
    for (hi = 0; hi < 12 && vent_valve_ctl_o !== 1'b1; hi++) tick(1);
    chk_bit(vent_valve_ctl_o, 1'b1);
    wr(`NIBP_OFF_VENT, 32'h0000_4003);
    tick(2);
    chk_bit(vent_valve_enable_o, 1'b0);
    chk_word(prop_bleed_valve_o, 8'h40);
    wr(`NIBP_OFF_VENT, 32'h0000_4000);
    tick(2);
    chk_bit(vent_valve_enable_o, 1'b0);
    // Neonate pump with valves open: half duty over one PWM period
    wr(`NIBP_OFF_PORT1, 32'h0);
    wr(`NIBP_OFF_PUMP, 32'h0000_8003);
    tick(8);
    hi = 0;
    for (i = 0; i < 256 * PWM; i++) begin
      tick(1);
      hi += (pump_o === 1'b1);
    end
    chk_bit(hi >= 128 * PWM - 2 && hi <= 128 * PWM + 2, 1'b1);
    chk_bit(neonate_flag_n_o, 1'b0);
    wr(`NIBP_OFF_PUMP, 32'h0000_8000);
    tick(3);
    chk_bit(neonate_flag_n_o, 1'b1);
    hi = 0;
    for (i = 0; i < SDIV * 10; i++) begin
      tick(1);
      hi += (adc_sample_o === 1'b1);
    end
    chk_word(hi, 10);
    // Pump runaway with the dump shut until the comparator trips
    wr(`NIBP_OFF_PORT1, 32'h0000_00F8);
    wr(`NIBP_OFF_VENT, 32'h0000_0001);
    wr(`NIBP_OFF_PUMP, 32'h0000_8001);
    tick(3);
    chk_bit(pump_o, 1'b1);
    for (i = 0; i < 3000 && overpressure_flag_o !== 1'b1; i++) tick(1);
    chk_bit(overpressure_compare_n_o, 1'b0);
    chk_bit(ovp_code_i > 10'h3C0, 1'b1);
    tick(2);
    chk_bit(pump_o, 1'b0);
    chk_word(prop_bleed_valve_o, `NIBP_BLEED_FULL);
    chk_bit(vent_valve_enable_o, 1'b0);
    chk_bit(hsi_bit1_o, 1'b1);
    module_reset_n_i <= 1'b0;
    tick(10);
    chk_bit(cpu_reset_n_o, 1'b0);
    module_reset_n_i <= 1'b1;
    for (i = 0; i < 12 && cpu_reset_n_o !== 1'b1; i++) tick(1);
    chk_bit(cpu_reset_n_o, 1'b1);
    chk_bit(overpressure_flag_o, 1'b1);
    // Full reset, then the switch path with the trip raised out of reach
    rst_i <= 1'b1;
    tick(4);
    rst_i <= 1'b0;
    tick(2);
    chk_bit(overpressure_flag_o, 1'b0);
    wr(`NIBP_OFF_TRIP, 32'h03FF_03FF);
    wr(`NIBP_OFF_PORT1, 32'h0000_00F8);
    wr(`NIBP_OFF_VENT, 32'h0000_0001);
    wr(`NIBP_OFF_PUMP, 32'h0000_8001);
    tick(3);
    chk_bit(pump_o, 1'b1);
    sw_req <= 1'b1;
    for (i = 0; i < 12 && overpressure_flag_o !== 1'b1; i++) tick(1);
    chk_bit(overpressure_flag_o, 1'b1);
    tick(2);
    chk_bit(pump_o, 1'b0);
    tally_and_finish();
  end
endmodule
bind nibp_glue nibp_glue_checker #(.SAMPLE_DIV(SAMPLE_DIV)) u_chk (.*);
